// ===== core/rbp_params.svh
// Purpose: Named constants for the reset and brownout supervisor
// Assumes: clk_sys at 25 MHz
// Notes:   Pin and glitch cycle counts derive from the times in ns
`ifndef RBP_PARAMS_SVH
`define RBP_PARAMS_SVH

`define RBP_CLK_NS          40
`define RBP_PIN_MIN_NS      50
`define RBP_GLITCH_NS       20
`define RBP_PIN_MIN_CYC     ((`RBP_PIN_MIN_NS + `RBP_CLK_NS - 1) / `RBP_CLK_NS)
`define RBP_GLITCH_CYC      (((`RBP_GLITCH_NS / `RBP_CLK_NS) < 1) ? 1 : (`RBP_GLITCH_NS / `RBP_CLK_NS))
`define RBP_OSC_START_CYC   16
`define RBP_BOOT_ADDR       32'h0000_0000

`define RBP_OFF_CTRL        8'h00
`define RBP_OFF_STATUS      8'h04
`define RBP_OFF_ISTAT       8'h08
`define RBP_OFF_IMASK       8'h0c
`define RBP_OFF_CAUSE       8'h10

`define RBP_CTRL_IRQ_SEL    1:0
`define RBP_CTRL_RST_SEL    3:2
`define RBP_CTRL_RST_EN     4
`define RBP_CTRL_STRAP_DIS  5
`define RBP_CTRL_RESET      6'h00

`define RBP_EV_BROWN        0
`define RBP_EV_WDT          1

`define RBP_CAUSE_PIN       0
`define RBP_CAUSE_WDT       1
`define RBP_CAUSE_POR       2
`define RBP_CAUSE_BROWN     3

`define RBP_RESP_OKAY       2'h0
`define RBP_RESP_SLVERR     2'h2

`endif

// ===== core/rbp_pkg.sv
// Purpose: Types for the reset and brownout supervisor
// Assumes: nothing
// Notes:   Codes written out in binary
package rbp_pkg;
	typedef enum logic [2:0]
	{
		RBP_ST_HOLD  = 3'b000,
		RBP_ST_OSC   = 3'b001,
		RBP_ST_FLASH = 3'b010,
		RBP_ST_PROT  = 3'b011,
		RBP_ST_RUN   = 3'b100
	} rbp_state_t;

	typedef enum logic [1:0]
	{
		RBP_LVL_NONE  = 2'b00,
		RBP_LVL_ONE   = 2'b01,
		RBP_LVL_TWO   = 2'b10,
		RBP_LVL_THREE = 2'b11
	} rbp_lvl_t;
endpackage

// ===== core/rbp_prot_if.sv
// Purpose: Carries the protection word and its decoded level
// Assumes: decoder is combinational
// Notes:   none
`timescale 1ns/1ps
interface rbp_prot_if;
	import rbp_pkg::*;
	logic [31:0] word;
	rbp_lvl_t    level;
	logic        no_boot;

	modport dec (input word, output level, output no_boot);
	modport seq (output word, input level, input no_boot);
endinterface

// ===== core/rbp_prot_decode.sv
// Purpose: Maps the flash protection word to a level
// Assumes: patterns are set by parameters
// Notes:   Unknown words mean no protection
`timescale 1ns/1ps
module rbp_prot_decode
	import rbp_pkg::*;
#(
	parameter logic [31:0] PAT_ONE   = 32'h1111_0001,
	parameter logic [31:0] PAT_TWO   = 32'h2222_0002,
	parameter logic [31:0] PAT_THREE = 32'h3333_0003,
	parameter logic [31:0] PAT_NOBL  = 32'h4444_0004
)
(
	// Word in, level out
	rbp_prot_if.dec p
);
	function automatic rbp_lvl_t rbp_lvl_of(input logic [31:0] w);
		if (w == PAT_ONE)
		begin
			return RBP_LVL_ONE;
		end
		else if (w == PAT_TWO)
		begin
			return RBP_LVL_TWO;
		end
		else if (w == PAT_THREE)
		begin
			return RBP_LVL_THREE;
		end
		return RBP_LVL_NONE;
	endfunction

	assign p.level   = rbp_lvl_of(p.word);
	assign p.no_boot = (p.word == PAT_NOBL);
endmodule

// ===== core/rbp_pin_filter.sv
// Purpose: Qualifies the external reset pin
// Assumes: pin sampled as synchronous input
// Notes:   Short lows are dropped, long lows held
`timescale 1ns/1ps
`include "rbp_params.svh"
module rbp_pin_filter
#(
	parameter int MIN_CYC    = `RBP_PIN_MIN_CYC,
	parameter int GLITCH_CYC = `RBP_GLITCH_CYC
)
(
	// Clock and reset
	input  wire logic clk_sys,
	input  wire logic rstn,
	// Pin and request
	input  wire logic pin_n,
	output logic      req
);
	typedef struct packed
	{
		logic [3:0] cnt;
		logic       req;
	} rbp_flt_t;

	rbp_flt_t s_q;
	rbp_flt_t s_d;

	if (GLITCH_CYC >= MIN_CYC || MIN_CYC > 15 || MIN_CYC < 1)
	begin
		$error("rbp_pin_filter: bad cycle counts");
	end

	always_comb
	begin
		s_d = s_q;
		if (pin_n)
		begin
			s_d.cnt = 4'h0;
			s_d.req = 1'b0;
		end
		else if (s_q.cnt < 4'(MIN_CYC))
		begin
			s_d.cnt = s_q.cnt + 4'h1;
		end
		// Low must last the full width to count
		if (!pin_n && s_q.cnt >= 4'(MIN_CYC - 1))
		begin
			s_d.req = 1'b1;
		end
	end

	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
		begin
			s_q <= '0;
		end
		else
		begin
			s_q <= s_d;
		end
	end

	assign req = s_q.req;
endmodule

// ===== core/rbp_top.sv
// Purpose: Reset merge, boot sequence, brownout and protection gating
// Assumes: AXI4-Lite master keeps one write and one read in flight
// Notes:   CTRL and IMASK survive chip reset; only rstn clears them
`timescale 1ns/1ps
`include "rbp_params.svh"

module rbp_top
	import rbp_pkg::*;
#(
	parameter int          OSC_START_CYC = `RBP_OSC_START_CYC,
	parameter logic [31:0] PAT_ONE       = 32'h1111_0001,
	parameter logic [31:0] PAT_TWO       = 32'h2222_0002,
	parameter logic [31:0] PAT_THREE     = 32'h3333_0003,
	parameter logic [31:0] PAT_NOBL      = 32'h4444_0004
)
(
	// Clock and reset
	input  wire logic        clk_sys,
	input  wire logic        rstn,
	// Reset sources and supply
	input  wire logic        rst_pin_n,
	input  wire logic        wdt_rst_req,
	input  wire logic        por_n,
	input  wire logic        supply_ok,
	input  wire logic [3:0]  brownout_below,
	// Boot inputs
	input  wire logic        boot_strap_pin,
	input  wire logic        flash_init_done,
	input  wire logic [31:0] prot_word,
	input  wire logic        app_flash_req,
	// Sequencer outputs
	output logic             chip_rst,
	output logic             periph_rst_n,
	output logic             core_rst_n,
	output logic [31:0]      boot_addr,
	output logic             osc_en,
	output logic             flash_init,
	// Protection outputs
	output logic [1:0]       prot_level,
	output logic             debug_block,
	output logic             boot_entry,
	output logic             boot_sector0_lock,
	output logic             boot_erase_only,
	output logic             app_flash_grant,
	output logic             irq,
	// AXI4-Lite slave
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready
);
	typedef struct packed
	{
		rbp_state_t  st;
		logic [15:0] cnt;
		logic        chip_rst;
		logic        periph_rst_n;
		logic        core_rst_n;
		logic [31:0] boot_addr;
		logic        osc_en;
		logic        flash_init;
		rbp_lvl_t    lvl;
		logic        debug_block;
		logic        boot_entry;
		logic        s0_lock;
		logic        erase_only;
		logic        flash_grant;
		logic [5:0]  ctrl;
		logic [1:0]  imask;
		logic [1:0]  istat;
		logic [3:0]  cause;
		logic        brown_prev;
		logic        wdt_prev;
		logic        irq;
		logic        aw_have;
		logic [7:0]  aw_addr;
		logic        w_have;
		logic [31:0] w_data;
		logic        w_en;
		logic        awready;
		logic        wready;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        arready;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
	} rbp_top_t;

	rbp_top_t s_q;
	rbp_top_t s_d;
	logic     pin_req;
	logic     brown_irq_lvl;
	logic     brown_rst_lvl;
	logic     any_src;

	rbp_prot_if prot ();

	if (OSC_START_CYC < 1 || OSC_START_CYC > 65535)
	begin
		$error("rbp_top: OSC_START_CYC out of range");
	end

	rbp_pin_filter #(
		.MIN_CYC    (`RBP_PIN_MIN_CYC),
		.GLITCH_CYC (`RBP_GLITCH_CYC)
	) u_pin (
		.clk_sys (clk_sys),
		.rstn    (rstn),
		.pin_n   (rst_pin_n),
		.req     (pin_req)
	);

	rbp_prot_decode #(
		.PAT_ONE   (PAT_ONE),
		.PAT_TWO   (PAT_TWO),
		.PAT_THREE (PAT_THREE),
		.PAT_NOBL  (PAT_NOBL)
	) u_dec (
		.p (prot.dec)
	);

	assign prot.word = prot_word;

	// Register read mux, zero above each field
	function automatic logic [32:0] rbp_read(input rbp_top_t s, input logic [7:0] a, input logic [3:0] below);
		logic [32:0] r;
		r = {1'b0, 32'h0};
		case (a)
			`RBP_OFF_CTRL:   r[5:0] = s.ctrl;
			`RBP_OFF_STATUS: r[9:0] = {s.boot_entry, s.debug_block, s.lvl, 2'h0, below};
			`RBP_OFF_ISTAT:  r[1:0] = s.istat;
			`RBP_OFF_IMASK:  r[1:0] = s.imask;
			`RBP_OFF_CAUSE:  r[3:0] = s.cause;
			default:         r[32]  = 1'b1;
		endcase
		return r;
	endfunction

	function automatic logic rbp_mapped(input logic [7:0] a);
		return (a == `RBP_OFF_CTRL || a == `RBP_OFF_STATUS || a == `RBP_OFF_ISTAT ||
			a == `RBP_OFF_IMASK || a == `RBP_OFF_CAUSE);
	endfunction

	assign brown_irq_lvl = brownout_below[s_q.ctrl[`RBP_CTRL_IRQ_SEL]];
	assign brown_rst_lvl = s_q.ctrl[`RBP_CTRL_RST_EN] & brownout_below[s_q.ctrl[`RBP_CTRL_RST_SEL]];
	assign any_src       = pin_req | wdt_rst_req | ~por_n | brown_rst_lvl;

	always_comb
	begin
		logic [32:0] rd;
		logic        rd_istat;
		logic [1:0]  ev;
		rd       = {1'b0, 32'h0};
		rd_istat = 1'b0;
		ev       = 2'h0;
		s_d      = s_q;

		// Boot sequencer
		case (s_q.st)
			RBP_ST_HOLD:
			begin
				if (!any_src && supply_ok)
				begin
					s_d.st     = RBP_ST_OSC;
					s_d.osc_en = 1'b1;
					s_d.cnt    = 16'(OSC_START_CYC - 1);
				end
			end
			RBP_ST_OSC:
			begin
				if (s_q.cnt == 16'h0)
				begin
					s_d.st         = RBP_ST_FLASH;
					s_d.flash_init = 1'b1;
				end
				else
				begin
					s_d.cnt = s_q.cnt - 16'h1;
				end
			end
			RBP_ST_FLASH:
			begin
				if (flash_init_done)
				begin
					s_d.st         = RBP_ST_PROT;
					s_d.flash_init = 1'b0;
				end
			end
			RBP_ST_PROT:
			begin
				// Latched only here, so gating is fixed until next reset
				s_d.lvl         = prot.level;
				s_d.debug_block = (prot.level != RBP_LVL_NONE);
				s_d.s0_lock     = (prot.level == RBP_LVL_ONE);
				s_d.erase_only  = (prot.level == RBP_LVL_TWO);
				s_d.boot_entry  = !boot_strap_pin && !prot.no_boot &&
					!s_q.ctrl[`RBP_CTRL_STRAP_DIS] &&
					(prot.level != RBP_LVL_THREE);
				s_d.periph_rst_n = 1'b1;
				s_d.boot_addr    = `RBP_BOOT_ADDR;
				s_d.st           = RBP_ST_RUN;
			end
			RBP_ST_RUN:
			begin
				s_d.core_rst_n = 1'b1;
				s_d.chip_rst   = 1'b0;
			end
			default:
			begin
				s_d.st = RBP_ST_HOLD;
			end
		endcase

		// Any source restarts the whole sequence
		if (any_src)
		begin
			s_d.st           = RBP_ST_HOLD;
			s_d.chip_rst     = 1'b1;
			s_d.periph_rst_n = 1'b0;
			s_d.core_rst_n   = 1'b0;
			s_d.osc_en       = 1'b0;
			s_d.flash_init   = 1'b0;
			s_d.boot_entry   = 1'b0;
			s_d.cause        = {brown_rst_lvl, ~por_n, wdt_rst_req, pin_req};
		end

		s_d.flash_grant = app_flash_req && s_q.core_rst_n;

		// Events
		s_d.brown_prev = brown_irq_lvl;
		s_d.wdt_prev   = wdt_rst_req;
		ev[`RBP_EV_BROWN] = brown_irq_lvl && !s_q.brown_prev;
		ev[`RBP_EV_WDT] = wdt_rst_req && !s_q.wdt_prev;

		// Write channel
		if (s_axi_awvalid && s_q.awready)
		begin
			s_d.aw_have = 1'b1;
			s_d.aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_q.wready)
		begin
			s_d.w_have = 1'b1;
			s_d.w_data = s_axi_wdata;
			s_d.w_en   = s_axi_wstrb[0];
		end
		if (s_q.aw_have && s_q.w_have && !s_q.bvalid)
		begin
			s_d.aw_have = 1'b0;
			s_d.w_have  = 1'b0;
			s_d.bvalid  = 1'b1;
			s_d.bresp   = rbp_mapped(s_q.aw_addr) ? `RBP_RESP_OKAY : `RBP_RESP_SLVERR;
			if (s_q.w_en)
			begin
				case (s_q.aw_addr)
					`RBP_OFF_CTRL:  s_d.ctrl  = s_q.w_data[5:0];
					`RBP_OFF_IMASK: s_d.imask = s_q.w_data[1:0];
					default:        s_d.bresp = s_d.bresp;
				endcase
			end
		end
		if (s_q.bvalid && s_axi_bready)
		begin
			s_d.bvalid = 1'b0;
		end
		s_d.awready = !s_d.aw_have && !s_d.bvalid;
		s_d.wready  = !s_d.w_have && !s_d.bvalid;

		// Read channel
		if (s_axi_arvalid && s_q.arready)
		begin
			rd        = rbp_read(s_q, s_axi_araddr, brownout_below);
			rd_istat  = (s_axi_araddr == `RBP_OFF_ISTAT);
			s_d.rdata = rd[31:0];
			s_d.rresp = rd[32] ? `RBP_RESP_SLVERR : `RBP_RESP_OKAY;
			s_d.rvalid = 1'b1;
		end
		if (s_q.rvalid && s_axi_rready)
		begin
			s_d.rvalid = 1'b0;
		end
		s_d.arready = !s_d.rvalid;

		// Read clears, a same-cycle event still sets
		s_d.istat = (s_q.istat & ~{2{rd_istat}}) | ev;
		s_d.irq   = |(s_d.istat & s_d.imask);
	end

	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
		begin
			s_q          <= '0;
			s_q.st       <= RBP_ST_HOLD;
			s_q.chip_rst <= 1'b1;
			s_q.ctrl     <= `RBP_CTRL_RESET;
		end
		else
		begin
			s_q <= s_d;
		end
	end

	assign chip_rst          = s_q.chip_rst;
	assign periph_rst_n      = s_q.periph_rst_n;
	assign core_rst_n        = s_q.core_rst_n;
	assign boot_addr         = s_q.boot_addr;
	assign osc_en            = s_q.osc_en;
	assign flash_init        = s_q.flash_init;
	assign prot_level        = s_q.lvl;
	assign debug_block       = s_q.debug_block;
	assign boot_entry        = s_q.boot_entry;
	assign boot_sector0_lock = s_q.s0_lock;
	assign boot_erase_only   = s_q.erase_only;
	assign app_flash_grant   = s_q.flash_grant;
	assign irq               = s_q.irq;
	assign s_axi_awready     = s_q.awready;
	assign s_axi_wready      = s_q.wready;
	assign s_axi_bresp       = s_q.bresp;
	assign s_axi_bvalid      = s_q.bvalid;
	assign s_axi_arready     = s_q.arready;
	assign s_axi_rdata       = s_q.rdata;
	assign s_axi_rresp       = s_q.rresp;
	assign s_axi_rvalid      = s_q.rvalid;
endmodule

// ===== bench/rbp_chk_props.sv
// Purpose: Port checks for the reset supervisor
// Assumes: one clock domain, rstn async low
// Notes:   Bound to rbp_top from the bench top
`timescale 1ns/1ps
module rbp_chk
(
	// Clock and reset
	input wire logic        clk_sys,
	input wire logic        rstn,
	// Sources
	input wire logic        rst_pin_n,
	input wire logic        wdt_rst_req,
	input wire logic        por_n,
	input wire logic        supply_ok,
	input wire logic        app_flash_req,
	// Watched outputs
	input wire logic        chip_rst,
	input wire logic        periph_rst_n,
	input wire logic        core_rst_n,
	input wire logic [31:0] boot_addr,
	input wire logic        osc_en,
	input wire logic        flash_init,
	input wire logic [1:0]  prot_level,
	input wire logic        debug_block,
	input wire logic        boot_entry,
	input wire logic        boot_sector0_lock,
	input wire logic        boot_erase_only,
	input wire logic        app_flash_grant,
	input wire logic        irq
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rstn);
	a_source_reset: assert property ((wdt_rst_req || !por_n) |=> chip_rst)
		else $error("no chip reset after request");
	a_pin_reset: assert property (!rst_pin_n [*2] |-> ##[1:2] chip_rst)
		else $error("long pin low not taken");
	a_osc_supply: assert property (!por_n ##1 !supply_ok |-> !osc_en)
		else $error("oscillator on before supply");
	a_flash_after_osc: assert property ($rose(flash_init) |-> $past(osc_en))
		else $error("flash init before oscillator");
	a_fetch_zero: assert property ($rose(core_rst_n) |-> boot_addr == 32'h0 && !chip_rst)
		else $error("core released with bad fetch address");
	a_periph_first: assert property ($rose(core_rst_n) |-> $past(periph_rst_n))
		else $error("core released before peripherals");
	a_level_hold: assert property (core_rst_n ##1 core_rst_n |-> $stable(prot_level))
		else $error("level changed at run time");
	a_debug_gate: assert property (core_rst_n |-> debug_block == (prot_level != 2'h0))
		else $error("debug gate wrong");
	a_lock_one: assert property (core_rst_n |-> boot_sector0_lock == (prot_level == 2'h1))
		else $error("sector lock wrong");
	a_erase_two: assert property (core_rst_n |-> boot_erase_only == (prot_level == 2'h2))
		else $error("erase only wrong");
	a_level3_closed: assert property (core_rst_n && prot_level == 2'h3 |-> !boot_entry)
		else $error("boot entry at level three");
	a_flash_call_free: assert property (app_flash_req && core_rst_n ##1 core_rst_n |-> app_flash_grant)
		else $error("flash call refused");
	cover property ($rose(core_rst_n));
	cover property ($rose(irq));
	cover property (core_rst_n && boot_entry);
endmodule

// ===== bench/rbp_board.sv
// Purpose: Board side: reset pin, supply, strap, flash
// Assumes: requests change just after clock edges
// Notes:   Supply ramps 3 cycles after power-on
`timescale 1ns/1ps
module rbp_board
(
	// Clock
	input  wire logic       clk_sys,
	// Requests from the bench, and flash_init from the design
	input  wire logic       pin_lo,
	input  wire logic       por_lo,
	input  wire logic [2:0] sag,
	input  wire logic       strap_lo,
	input  wire logic       slow,
	input  wire logic       flash_init,
	// Toward the design
	output logic            rst_pin_n,
	output logic            por_n,
	output logic            supply_ok,
	output logic [3:0]      brownout_below,
	output logic            boot_strap_pin,
	output logic            flash_init_done
);
	int ramp = 0;
	int busy = 0;
	assign rst_pin_n = !pin_lo;
	assign por_n = !por_lo;
	assign boot_strap_pin = !strap_lo;
	assign supply_ok = ramp == 0;
	assign flash_init_done = flash_init && busy >= (slow ? 6 : 1);
	always_comb
		for (int k = 0; k < 4; k++)
			brownout_below[k] = k < int'(sag);
	always @(posedge clk_sys)
	begin
		ramp <= por_lo ? 3 : (ramp > 0 ? ramp - 1 : 0);
		busy <= flash_init ? busy + 1 : 0;
	end
endmodule

// ===== bench/test_reset_brownout_protection.sv
// Purpose: Self-checking bench for the reset supervisor
// Assumes: 25 MHz clk_sys, short oscillator count
// Notes:   Board model drives pins and supply
`timescale 1ns/1ps
module test_reset_brownout_protection;
	localparam logic [31:0] P1 = 32'h5a5a_0101;
	localparam logic [31:0] P2 = 32'h5a5a_0202;
	localparam logic [31:0] P3 = 32'h5a5a_0303;
	localparam logic [31:0] PN = 32'h5a5a_0404;
	logic        clk_sys = 1'b0;
	logic        rstn, wdt_rst_req, app_flash_req, pin_lo, por_lo, strap_lo, slow;
	logic        rst_pin_n, por_n, supply_ok, boot_strap_pin, flash_init_done, flash_init;
	logic        chip_rst, periph_rst_n, core_rst_n, osc_en, debug_block, boot_entry, irq;
	logic        boot_sector0_lock, boot_erase_only, app_flash_grant;
	logic        s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, s_axi_awready, s_axi_wready;
	logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic        s_axi_bready = 1'b1;
	logic        s_axi_rready = 1'b1;
	logic [1:0]  prot_level, s_axi_bresp, s_axi_rresp, r;
	logic [2:0]  sag;
	logic [3:0]  brownout_below;
	logic [3:0]  s_axi_wstrb = 4'hf;
	logic [7:0]  s_axi_awaddr, s_axi_araddr;
	logic [31:0] prot_word, boot_addr, s_axi_wdata, s_axi_rdata, d, w, ctl;
	logic [31:0] pat [5] = '{32'h0, P1, P2, P3, PN};
	int          num_errors, check_count, cyc, i, n;

	rbp_top #(.OSC_START_CYC(3), .PAT_ONE(P1), .PAT_TWO(P2), .PAT_THREE(P3), .PAT_NOBL(PN)) uut (.*);
	rbp_board board (.*);

	initial forever #20 clk_sys = ~clk_sys;

	function automatic logic [1:0] lvl(input logic [31:0] v);
		return v == P1 ? 2'h1 : v == P2 ? 2'h2 : v == P3 ? 2'h3 : 2'h0;
	endfunction

	function automatic logic [3:0] below(input int s);
		return 4'((1 << s) - 1);
	endfunction

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		check_count++;
		if (g !== e)
		begin
			$display("wrong value %s expected %h seen %h", nm, e, g);
			num_errors++;
		end
	endtask

	task close_out;
		if (num_errors == 0 && check_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		do
		begin
			@(posedge clk_sys);
			if (s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'b0;
		end
		while (!s_axi_bvalid);
		chk("bresp", a > 8'h10 ? 2'h2 : 2'h0, s_axi_bresp);
	endtask

	task automatic rd(input logic [7:0] a);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		do
		begin
			@(posedge clk_sys);
			if (s_axi_arready)
				s_axi_arvalid <= 1'b0;
		end
		while (!s_axi_rvalid);
		d = s_axi_rdata;
		r = s_axi_rresp;
	endtask

	task automatic up;
		n = 0;
		while (!core_rst_n && n < 300)
		begin
			@(posedge clk_sys);
			n++;
		end
		chk("core release", 1, core_rst_n);
	endtask

	// Two-cycle pin pulse, strap held until the core runs
	task automatic boot(input logic [31:0] v, input logic s);
		prot_word <= v;
		strap_lo <= s;
		slow <= 1'($urandom);
		pin_lo <= 1'b1;
		repeat (2) @(posedge clk_sys);
		pin_lo <= 1'b0;
		repeat (3) @(posedge clk_sys);
		chk("pin reset", 1, chip_rst);
		up();
		chk("level", lvl(v), prot_level);
		chk("debug", lvl(v) != 2'h0, debug_block);
		chk("sector lock", lvl(v) == 2'h1, boot_sector0_lock);
		chk("erase only", lvl(v) == 2'h2, boot_erase_only);
		chk("boot entry", s && lvl(v) != 2'h3 && v != PN && !ctl[5], boot_entry);
		chk("fetch", 0, boot_addr);
		chk("periph", 1, periph_rst_n);
		rd(8'h04);
		chk("status gate", {lvl(v) != 2'h0, lvl(v)}, d[8:6]);
		app_flash_req <= 1'b1;
		strap_lo <= 1'b0;
		repeat (2) @(posedge clk_sys);
		chk("flash call", 1, app_flash_grant);
		app_flash_req <= 1'b0;
	endtask

	always @(posedge clk_sys)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			num_errors++;
			close_out();
		end
	end

	initial
	begin
		{rstn, wdt_rst_req, app_flash_req, pin_lo, por_lo, strap_lo, slow} = 7'h0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, sag} = 6'h0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, prot_word, ctl} = '0;
		n = $urandom(32'h2ab7);
		repeat (8) @(posedge clk_sys);
		rstn <= 1'b1;
		repeat (2) @(posedge clk_sys);
		rd(8'h00);
		chk("ctrl reset", 0, d);
		up();
		pin_lo <= 1'b1;
		@(posedge clk_sys);
		pin_lo <= 1'b0;
		repeat (5) @(posedge clk_sys);
		chk("glitch", 0, chip_rst);
		ctl = 32'h18;
		wr(8'h00, ctl);
		sag <= 3'h2;
		repeat (6) @(posedge clk_sys);
		chk("no bod reset", 0, chip_rst);
		for (i = 0; i < 4; i++)
		begin
			pin_lo <= i == 0;
			wdt_rst_req <= i == 1;
			por_lo <= i == 2;
			sag <= i == 3 ? 3'h3 : 3'h0;
			repeat (4) @(posedge clk_sys);
			chk("source reset", 1, chip_rst);
			{pin_lo, wdt_rst_req, por_lo, sag} <= 6'h0;
			up();
			rd(8'h10);
			chk("cause", 1, d[i]);
		end
		rd(8'h08);
		for (i = 0; i < 4; i++)
		begin
			ctl = i;
			w = $urandom;
			wr(8'h00, ctl);
			wr(8'h0c, {31'h0, w[0]});
			sag <= 3'(i);
			repeat (6) @(posedge clk_sys);
			chk("irq above", 0, irq);
			sag <= 3'(i + 1);
			repeat (6) @(posedge clk_sys);
			chk("irq", w[0], irq);
			rd(8'h04);
			chk("status", below(i + 1), d[3:0]);
			sag <= 3'h0;
			rd(8'h08);
			chk("event", 1, d[0]);
			repeat (2) @(posedge clk_sys);
			chk("irq cleared", 0, irq);
		end
		for (i = 0; i < 7; i++)
		begin
			if (i == 5)
			begin
				ctl = 32'h20;
				wr(8'h00, ctl);
			end
			w = (i == 0 || i > 4) ? $urandom : pat[i];
			boot(w, i != 6);
		end
		wr(8'h40, 32'hffff_ffff);
		rd(8'h00);
		chk("ctrl", ctl, d);
		rd(8'h40);
		chk("unmapped", 2'h2, r);
		close_out();
	end
endmodule

bind rbp_top rbp_chk chk (.*);
